/* File: ccd_fe_pkg.sv */
// constants shared by the ccd front end timing port and its timing host
// assumes both ends include this package and refer to it by scope
package ccd_fe_pkg;
    // ****************************************
    // widths and register addresses
    // ****************************************
    localparam int unsigned PIX_W = 12;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned PIPE_LAT = 10;
    localparam logic [3:0] ADDR_OPER = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h1;
    localparam logic [3:0] ADDR_CLAMP = 4'h2;
    localparam logic [3:0] ADDR_GAIN = 4'h3;
    // field positions
    localparam int unsigned OPER_BLANK_LVL_BIT = 6;
    localparam int unsigned OPER_CLAMP_OFF_BIT = 3;
    localparam int unsigned CTRL_STROBE_POL_BIT = 0;
    // reset values
    localparam logic [11:0] OPER_RST = 12'h000;
    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam logic [11:0] CLAMP_RST = 12'h080;
    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned REF_CLK_NS = 40;
    localparam int unsigned SCK_MIN_PERIOD_NS = 100;
    localparam int unsigned SCK_HALF_CYC =
        (SCK_MIN_PERIOD_NS + 2 * REF_CLK_NS - 1) / (2 * REF_CLK_NS);
    localparam int unsigned CLAMP_MIN_PIX = 2;
    localparam int unsigned CLAMP_REC_PIX = 20;
endpackage

/* File: ccd_fe_if.sv */
// link between the timing host and the front end timing port
// assumes the bench supplies the pixel clock and joins the two ends
`timescale 1ns/1ps
interface ccd_fe_if;
    logic output_latch_clock; // pixel clock from bench
    logic reference_sample_strobe;
    logic data_sample_strobe;
    logic black_clamp_strobe;
    logic preblank_strobe;
    logic serial_load_strobe; // low during a write
    logic serial_clock;
    logic serial_data_in;
    logic [11:0] pixel_data_out;
    modport dev (input output_latch_clock, reference_sample_strobe,
        data_sample_strobe, black_clamp_strobe, preblank_strobe,
        serial_load_strobe, serial_clock, serial_data_in,
        output pixel_data_out);
    modport host (input output_latch_clock, pixel_data_out,
        output reference_sample_strobe, data_sample_strobe,
        black_clamp_strobe, preblank_strobe, serial_load_strobe,
        serial_clock, serial_data_in);
endinterface

/* File: ccd_fe_dev.sv */
// front end timing port: strobes, clamp, pipeline and serial registers
// assumes link pins may arrive asynchronous to the output latch clock
`timescale 1ns/1ps
module ccd_fe_dev (
    input wire logic rstn,
    input wire logic ce,
    ccd_fe_if.dev lnk,
    input wire logic [11:0] sample_in, // digitised level at reference and data strobes
    output logic [11:0] clamp_level,
    output logic [9:0] gain_code,
    output logic clamp_active
);
    // ****************************************
    // pin synchronisers on the pixel clock
    // ****************************************
    logic [4:0] s1_ff; // first stage, read only by s2
    logic [4:0] s2_ff;
    logic [4:0] s3_ff; // edge history
    wire clk = lnk.output_latch_clock;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_ff <= 5'h1c;
            s2_ff <= 5'h1c;
            s3_ff <= 5'h1c;
        end else if (ce) begin
            s1_ff <= {lnk.serial_load_strobe, lnk.serial_clock,
                lnk.serial_data_in, lnk.black_clamp_strobe,
                lnk.preblank_strobe};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    wire sl_now = s2_ff[4];
    wire sl_rise = s2_ff[4] & ~s3_ff[4];
    wire sck_rise = s2_ff[3] & ~s3_ff[3];
    wire sdat = s2_ff[2];
    logic [11:0] oper_ff, ctrl_ff, clamp_ff, gain_ff;
    // polarity bit: one means active high
    wire pol = ctrl_ff[ccd_fe_pkg::CTRL_STROBE_POL_BIT];
    wire clamp_on = (s2_ff[1] ~^ pol)
        & ~oper_ff[ccd_fe_pkg::OPER_CLAMP_OFF_BIT];
    wire blank_on = s2_ff[0] ~^ pol;
    // ****************************************
    // serial receiver
    // ****************************************
    logic [11:0] sh_ff; // shift register
    logic [3:0] cnt_ff; // bits in current word
    logic got_addr_ff; // address field received
    logic [3:0] wa_ff; // target address
    logic [11:0] st_ff [4]; // staged words
    logic [3:0] stv_ff; // staged valid
    wire [11:0] sh_nxt = {sdat, sh_ff[11:1]}; // lsb first
    wire word_done = sck_rise & got_addr_ff & (cnt_ff == 4'd11);
    wire addr_done = sck_rise & ~got_addr_ff & (cnt_ff == 4'd3);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sh_ff <= 12'h000;
            cnt_ff <= 4'h0;
            got_addr_ff <= 1'b0;
            wa_ff <= 4'h0;
            stv_ff <= 4'h0;
            for (int i = 0; i < 4; i++) st_ff[i] <= 12'h000;
        end else if (ce) begin
            if (sl_now) begin
                // idle: restart framing
                cnt_ff <= 4'h0;
                got_addr_ff <= 1'b0;
            end else if (sck_rise) begin
                sh_ff <= sh_nxt;
                if (addr_done) begin
                    wa_ff <= sh_nxt[11:8];
                    got_addr_ff <= 1'b1;
                    cnt_ff <= 4'h0;
                end else if (word_done) begin
                    if (wa_ff < 4'd4) begin
                        st_ff[wa_ff[1:0]] <= sh_nxt;
                        stv_ff[wa_ff[1:0]] <= 1'b1;
                    end
                    wa_ff <= wa_ff + 4'h1;
                    cnt_ff <= 4'h0;
                end else begin
                    cnt_ff <= cnt_ff + 4'h1;
                end
            end
            if (sl_rise) stv_ff <= 4'h0;
        end
    end
    // apply staged words only on load strobe rise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oper_ff <= ccd_fe_pkg::OPER_RST;
            ctrl_ff <= ccd_fe_pkg::CTRL_RST;
            clamp_ff <= ccd_fe_pkg::CLAMP_RST;
            gain_ff <= 12'h000;
        end else if (ce && sl_rise) begin
            if (stv_ff[0]) oper_ff <= st_ff[0];
            if (stv_ff[1]) ctrl_ff <= st_ff[1];
            if (stv_ff[2]) clamp_ff <= st_ff[2];
            if (stv_ff[3]) gain_ff <= st_ff[3];
        end
    end
    assign clamp_level = clamp_ff;
    assign gain_code = gain_ff[9:0];
    // ****************************************
    // sample capture and pipeline
    // ****************************************
    // capture sampled levels on strobe rising edges; the level itself
    // comes from the analog side, here sample_in
    logic [11:0] ref_ff, dat_ff;
    always_ff @(posedge lnk.reference_sample_strobe or negedge rstn) begin
        if (!rstn) ref_ff <= 12'h000;
        else if (ce) ref_ff <= sample_in;
    end
    always_ff @(posedge lnk.data_sample_strobe or negedge rstn) begin
        if (!rstn) dat_ff <= 12'h000;
        else if (ce) dat_ff <= sample_in;
    end
    // full 12 bit path, no code is masked
    wire [11:0] cds = (dat_ff >= ref_ff) ? dat_ff - ref_ff : 12'h000;
    wire [11:0] blanked = oper_ff[ccd_fe_pkg::OPER_BLANK_LVL_BIT]
        ? clamp_ff : 12'h000;
    wire [11:0] stage0 = blank_on ? blanked : cds;
    logic [11:0] pipe_ff [ccd_fe_pkg::PIPE_LAT];
    logic clamp_ff_act;
    // fixed depth shift: latency never depends on data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < ccd_fe_pkg::PIPE_LAT; i++)
                pipe_ff[i] <= 12'h000;
            clamp_ff_act <= 1'b0;
        end else if (ce) begin
            pipe_ff[0] <= stage0;
            for (int i = 1; i < ccd_fe_pkg::PIPE_LAT; i++)
                pipe_ff[i] <= pipe_ff[i-1];
            clamp_ff_act <= clamp_on;
        end
    end
    assign lnk.pixel_data_out = pipe_ff[ccd_fe_pkg::PIPE_LAT-1];
    assign clamp_active = clamp_ff_act;
endmodule

/* File: ccd_fe_host.sv */
// timing generator and serial host driving the front end
// assumes ref_clk is unrelated to the pixel clock on the link
`timescale 1ns/1ps
module ccd_fe_host #(
    parameter int unsigned CLAMP_PIX = ccd_fe_pkg::CLAMP_REC_PIX
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    ccd_fe_if.host lnk,
    input wire logic wr_req, // one word write request
    input wire logic [3:0] wr_addr,
    input wire logic [11:0] wr_data,
    output logic wr_busy,
    input wire logic clamp_req, // level: ask for clamp run
    input wire logic blank_req,
    output logic [11:0] pix_word, // word seen on link, ref_clk domain
    output logic pix_valid
);
    // ****************************************
    // strobes on the pixel clock
    // ****************************************
    // strobes follow the pixel clock: reference in high half, data in low
    // half, giving half a period spacing
    wire pclk = lnk.output_latch_clock;
    logic [1:0] cr_s, br_s; // request syncs into pixel domain
    logic [4:0] ccnt_ff;
    always_ff @(posedge pclk or negedge rstn) begin
        if (!rstn) begin
            cr_s <= 2'b00;
            br_s <= 2'b00;
            ccnt_ff <= 5'h00;
        end else if (ce) begin
            cr_s <= {cr_s[0], clamp_req};
            br_s <= {br_s[0], blank_req};
            // clamp run lasts whole count, never under two pixels
            if (cr_s[1] && ccnt_ff == 5'h00)
                ccnt_ff <= 5'(CLAMP_PIX < ccd_fe_pkg::CLAMP_MIN_PIX
                    ? ccd_fe_pkg::CLAMP_MIN_PIX : CLAMP_PIX);
            else if (ccnt_ff != 5'h00)
                ccnt_ff <= ccnt_ff - 5'h01;
        end
    end
    assign lnk.reference_sample_strobe = pclk;
    assign lnk.data_sample_strobe = ~pclk;
    assign lnk.black_clamp_strobe = ccnt_ff != 5'h00;
    assign lnk.preblank_strobe = br_s[1];
    // ****************************************
    // serial writer on ref_clk
    // ****************************************
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001, S_LOW = 4'b0010, S_SHIFT = 4'b0100,
        S_END = 4'b1000
    } st_t;
    st_t st_ff;
    logic [15:0] sr_ff; // address then data, lsb first
    logic [4:0] bit_ff;
    logic [2:0] div_ff;
    logic sck_ff, sl_ff, sd_ff;
    logic pend_ff; // next bit due one cycle after a falling edge
    wire tick = div_ff == 3'(ccd_fe_pkg::SCK_HALF_CYC - 1);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= S_IDLE;
            sr_ff <= 16'h0000;
            bit_ff <= 5'h00;
            div_ff <= 3'h0;
            sck_ff <= 1'b0;
            sl_ff <= 1'b1;
            sd_ff <= 1'b0;
            pend_ff <= 1'b0;
        end else if (ce) begin
            div_ff <= tick ? 3'h0 : div_ff + 3'h1;
            // data moves a cycle after the fall so it holds past the edge
            if (pend_ff) begin
                sd_ff <= sr_ff[0];
                pend_ff <= 1'b0;
            end
            case (st_ff)
                S_IDLE: begin
                    if (wr_req) begin
                        sr_ff <= {wr_data, wr_addr};
                        sl_ff <= 1'b0;
                        bit_ff <= 5'h00;
                        st_ff <= S_LOW;
                    end
                end
                S_LOW: if (tick) begin
                    sd_ff <= sr_ff[0];
                    st_ff <= S_SHIFT;
                end
                S_SHIFT: if (tick) begin
                    sck_ff <= ~sck_ff;
                    if (sck_ff) begin // falling edge: next bit after hold
                        pend_ff <= 1'b1;
                        sr_ff <= {1'b0, sr_ff[15:1]};
                        if (bit_ff == 5'd15) st_ff <= S_END;
                        bit_ff <= bit_ff + 5'h01;
                    end
                end
                S_END: if (tick) begin
                    sl_ff <= 1'b1;
                    st_ff <= S_IDLE;
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end
    assign lnk.serial_clock = sck_ff;
    assign lnk.serial_load_strobe = sl_ff;
    assign lnk.serial_data_in = sd_ff;
    assign wr_busy = st_ff != S_IDLE;
    // ****************************************
    // pixel word crossing by toggle handshake
    // ****************************************
    logic tg_ff;
    logic [11:0] hold_ff;
    logic [1:0] ak_s; // acknowledge synced back into pixel domain
    logic [2:0] tg_s;
    // new word only once the previous toggle came back, so hold is steady
    always_ff @(posedge pclk or negedge rstn) begin
        if (!rstn) begin
            tg_ff <= 1'b0;
            hold_ff <= 12'h000;
            ak_s <= 2'b00;
        end else if (ce) begin
            ak_s <= {ak_s[0], tg_s[2]};
            if (ak_s[1] == tg_ff) begin
                tg_ff <= ~tg_ff;
                hold_ff <= lnk.pixel_data_out;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tg_s <= 3'h0;
            pix_word <= 12'h000;
            pix_valid <= 1'b0;
        end else if (ce) begin
            tg_s <= {tg_s[1:0], tg_ff};
            pix_valid <= tg_s[2] ^ tg_s[1];
            if (tg_s[2] ^ tg_s[1]) pix_word <= hold_ff;
        end
    end
endmodule

/* File: ccd_fe_chk.sv */
// checker for the serial and clamp wires of the front end link
// assumes the bench instantiates it beside the link and drives ref_clk
`timescale 1ns/1ps
module ccd_fe_chk (
    input wire logic ref_clk,
    input wire logic output_latch_clock,
    input wire logic rstn,
    input wire logic serial_load_strobe,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    input wire logic black_clamp_strobe
);
    // ****************************************
    // helper logic
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic [4:0] rise_cnt_ff; // serial clock rises in this frame
    logic sck_prev_ff; // last sampled serial clock
    wire sck_rise = serial_clock & ~sck_prev_ff;
    // count clears while the load strobe idles high
    wire [4:0] nxt_rise_cnt = serial_load_strobe ? 5'h00 :
        rise_cnt_ff + {4'h0, sck_rise};
    // counter of rises, reset to an empty frame
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rise_cnt_ff <= 5'h00;
            sck_prev_ff <= 1'b0;
        end else begin
            rise_cnt_ff <= nxt_rise_cnt;
            sck_prev_ff <= serial_clock;
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    a_sck_idle_low: assert property (serial_load_strobe |-> !serial_clock)
        else $error("serial clock moved outside a frame");
    a_sl_setup_sck: assert property ($rose(serial_clock) |->
        !$past(serial_load_strobe)) else $error("load strobe setup short");
    a_sl_hold_sck: assert property ($fell(serial_clock) |->
        !serial_load_strobe) else $error("load strobe hold short");
    a_data_setup: assert property ($rose(serial_clock) |->
        $stable(serial_data_in)) else $error("serial data setup short");
    a_data_hold: assert property ($fell(serial_clock) |->
        $stable(serial_data_in)) else $error("serial data hold short");
    a_sck_half_period: assert property ($rose(serial_clock) |=>
        serial_clock ##1 !serial_clock) else $error("serial clock too fast");
    a_frame_bit_count: assert property ($rose(serial_load_strobe) |->
        rise_cnt_ff == 5'h10) else $error("frame bit count wrong");
    // clamp strobe lives on the pixel clock, so it is watched there
    a_clamp_min_width: assert property (@(posedge output_latch_clock)
        $changed(black_clamp_strobe) |=> $stable(black_clamp_strobe))
        else $error("clamp strobe too short");
    c_frame: cover property ($rose(serial_load_strobe));
    c_clamp: cover property (@(posedge output_latch_clock)
        $changed(black_clamp_strobe));
    c_sck: cover property (sck_rise);
endmodule

/* File: ccd_fe_tb_top.sv */
// testbench joining timing host and front end across the link
// assumes the package, interface and both ends are compiled first
`timescale 1ns/1ps
module ccd_fe_tb_top;
    // ****************************************
    // clocks, wires, instances
    // ****************************************
    logic ref_clk = 1'b0; // host clock, 40 ns
    logic pclk = 1'b0; // pixel clock, 30 ns, free phase
    logic rstn = 1'b0;
    logic wr_req = 1'b0;
    logic [3:0] wr_addr = 4'h0;
    logic [11:0] wr_data = 12'h000;
    logic clamp_req = 1'b0;
    logic blank_req = 1'b0;
    logic [11:0] sample_in = 12'h000; // ramp so the pipeline moves
    logic wr_busy, pix_valid, clamp_active;
    logic [11:0] pix_word, clamp_level;
    logic [9:0] gain_code;
    int bad_count = 0;
    int n_checks = 0;
    always #20 ref_clk = ~ref_clk;
    always #15 pclk = ~pclk;
    always @(posedge pclk) sample_in <= sample_in + 12'h001;
    ccd_fe_if lnk();
    assign lnk.output_latch_clock = pclk;
    ccd_fe_dev ccd_fe_dev_i (.rstn(rstn), .ce(1'b1), .lnk(lnk),
        .sample_in(sample_in), .clamp_level(clamp_level),
        .gain_code(gain_code), .clamp_active(clamp_active));
    ccd_fe_host ccd_fe_host_i (.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1),
        .lnk(lnk), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_busy(wr_busy), .clamp_req(clamp_req), .blank_req(blank_req),
        .pix_word(pix_word), .pix_valid(pix_valid));
    ccd_fe_chk ccd_fe_chk_i (.ref_clk(ref_clk), .rstn(rstn),
        .output_latch_clock(pclk),
        .serial_load_strobe(lnk.serial_load_strobe),
        .serial_clock(lnk.serial_clock),
        .serial_data_in(lnk.serial_data_in),
        .black_clamp_strobe(lnk.black_clamp_strobe));
    // ****************************************
    // tasks
    // ****************************************
    // compare one value, report at once
    task automatic check(input string name, input logic [11:0] seen,
        input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic complete_run();
        if (bad_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one framed word; request pulsed for one cycle, address and data held until the host goes idle
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        int n;
        @(posedge ref_clk);
        #1;
        wr_addr = a;
        wr_data = d;
        wr_req = 1'b1;
        @(posedge ref_clk);
        #1;
        wr_req = 1'b0;
        n = 0;
        while (wr_busy !== 1'b0 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        check("wr_done", {11'h000, wr_busy}, 12'h000);
        // room for the three pixel clock sync of the load strobe
        repeat (8) @(posedge ref_clk);
    endtask
    // wait bounded for clamp gate to reach a level
    task automatic clamp_wait(input logic lvl);
        int n;
        n = 0;
        while (clamp_active !== lvl && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        check("clamp_active", {11'h000, clamp_active}, {11'h000, lvl});
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        #400000;
        bad_count++;
        complete_run();
    end
    initial begin
        logic [11:0] gains [2];
        gains = '{12'h3ff, 12'h2c5};
        repeat (12) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        check("clamp_rst", clamp_level, 12'h080);
        check("gain_rst", {2'h0, gain_code}, 12'h000);
        wr(ccd_fe_pkg::ADDR_CTRL, 12'h001);
        // mid-frame the old gain must still stand
        fork
            begin
                repeat (40) @(posedge ref_clk);
                check("gain_mid", {2'h0, gain_code}, 12'h000);
            end
        join_none
        foreach (gains[i]) begin
            wr(ccd_fe_pkg::ADDR_GAIN, gains[i]);
            check("gain", {2'h0, gain_code}, gains[i] & 12'h3ff);
        end
        wr(4'h4, 12'h0aa);
        check("clamp_unmapped", clamp_level, 12'h080);
        wr(ccd_fe_pkg::ADDR_CLAMP, 12'h0ff);
        check("clamp_lvl", clamp_level, 12'h0ff);
        #1 clamp_req = 1'b1;
        clamp_wait(1'b1);
        @(posedge ref_clk);
        #1 clamp_req = 1'b0;
        repeat (60) @(posedge ref_clk);
        clamp_wait(1'b0);
        #1 blank_req = 1'b1;
        repeat (40) @(posedge pclk);
        #1;
        check("blank_zero", lnk.pixel_data_out, 12'h000);
        check("pix_word", pix_word, 12'h000);
        wr(ccd_fe_pkg::ADDR_OPER, 12'h040);
        repeat (40) @(posedge pclk);
        #1;
        check("blank_clamp", lnk.pixel_data_out, 12'h0ff);
        #1 blank_req = 1'b0;
        complete_run();
    end
endmodule
